// ===== logic/dmfcs_sequencer.sv
// Sequencer that drives a dual 12x12 MAC device for FIR, complex and butterfly work
//
// Functional notes
// RQ1 - Device uses its four delay stores as banks for 32 tap pairs.
// RQ2 - Device sums two taps per clock into its accumulator.
// RQ3 - Symmetric filter: step delay selectors 0 to F, one per cycle.
// RQ4 - After a pass result is out, push one sample on even/odd stack.
// RQ5 - B and D selectors count up and down on alternate passes.
// RQ6 - Device output rate is clock over half the tap count.
// RQ7 - Non-symmetric: data to A, and via half-length delay line to C.
// RQ8 - Non-symmetric: same incrementing selector on all four ports.
// RQ9 - Upper word: round high, swap low; lower word: round low.
// RQ10 - Device adds A*B and C*D, each negated by its sign control.
// RQ11 - Complex product: cycle one negates second product, cycle two swaps B, D.
// RQ12 - Butterfly signs low/high, high/low, low/low, high/high.
// RQ13 - Last two butterfly steps swap twiddle parts and cascade imaginary A.
// RQ14 - Swap second vector parts between B and D before second sum.
// RQ15 - Device upper word is bits 23-8, lower word bits 15-0.
// RQ16 - Accumulate low loads the new sum; high adds to previous total.
// RQ17 - Port input enables go low only in cycles that push data.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
module dmfcs_sequencer import dmfcs_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output dmfcs_pins_type o_dev,
	input wire logic [SUM_W-1:0] i_dev_sum,
	output logic o_res_valid,
	input wire logic i_res_ready,
	output logic [SUM_W-1:0] o_res_data
);
	////////////////////////////////////////////////////////////////
	typedef struct packed {
		dmfcs_state_type st;
		dmfcs_mode_type mode;
		logic lsw;
		logic [SEL_W-1:0] step;
		logic dir;
		logic par;
		logic [1:0] pend;
		logic [RES_LAT-1:0] mark;
		logic [DATA_W-1:0] sample;
		logic [DATA_W-1:0] op_p;
		logic [DATA_W-1:0] op_r;
		logic [DATA_W-1:0] op_s;
		logic [DATA_W-1:0] op_t;
		logic [SUM_W-1:0] cas_re;
		logic [SUM_W-1:0] cas_im;
		logic [31:0] prdata;
		dmfcs_pins_type pins;
	} dmfcs_seq_state_type;
	dmfcs_seq_state_type q, n;

	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == ADR_CTRL) || (a == ADR_START) || (a == ADR_SAMPLE) ||
			(a == ADR_COEF) || (a == ADR_OPA) || (a == ADR_OPB) ||
			(a == ADR_CAS) || (a == ADR_STATUS);
	endfunction

	logic busy;
	logic apb_setup;
	logic apb_wr;
	logic refuse;
	logic credit_ok;
	logic capture;
	logic fifo_ready;
	logic nsym_push;
	logic [1:0] occ;
	logic [2:0] in_use;
	logic [SEL_W-1:0] rev_step;
	logic [DATA_W-1:0] tail;

	assign busy = q.st != ST_IDLE;
	assign apb_setup = i_psel && !i_penable;
	// Writes while a sequence runs would corrupt live operands
	assign refuse = !addr_mapped(i_paddr) || (i_pwrite && busy);
	assign apb_wr = i_psel && i_penable && i_pwrite && !refuse;
	assign o_pready = i_psel && i_penable;
	assign o_pslverr = i_psel && i_penable && refuse;
	assign o_prdata = q.prdata;
	assign o_dev = q.pins;
	assign capture = q.mark[RES_LAT-1];
	assign in_use = {1'b0, q.pend} + {1'b0, occ};
	// A result is only reserved when the buffer can take it, so the
	// device pipeline never has to be stalled mid-flight
	assign credit_ok = fifo_ready && (in_use < BUF_DEPTH);
	assign rev_step = TAP_LAST - q.step;
	assign nsym_push = (q.st == ST_PUSH) && (q.mode == MODE_FIR_NSYM);

	////////////////////////////////////////////////////////////////
	always_comb begin
		logic issue;
		issue = 1'b0;
		n = q;
		n.pins.port_a_input_enable_n = 1'b1; // [RQ17]
		n.pins.port_b_input_enable_n = 1'b1; // [RQ17]
		n.pins.port_c_input_enable_n = 1'b1; // [RQ17]
		n.pins.port_d_input_enable_n = 1'b1; // [RQ17]
		n.pins.first_product_negate = 1'b0;
		n.pins.second_product_negate = 1'b0;
		n.pins.accumulate_control = 1'b0;
		n.pins.round_control = !q.lsw; // [RQ9]
		n.pins.word_swap = q.lsw; // [RQ9] [RQ15]
		n.mark = {q.mark[RES_LAT-2:0], 1'b0};

		if (apb_setup) begin
			unique case (i_paddr)
				ADR_CTRL: n.prdata = {29'h0, q.lsw, q.mode};
				ADR_OPA: n.prdata = {4'h0, q.op_r, 4'h0, q.op_p};
				ADR_OPB: n.prdata = {4'h0, q.op_t, 4'h0, q.op_s};
				ADR_CAS: n.prdata = {q.cas_im, q.cas_re};
				ADR_SAMPLE: n.prdata = {20'h0, q.sample};
				ADR_STATUS: begin
					n.prdata = 32'h0;
					n.prdata[ST_BUSY_BIT] = busy;
					n.prdata[ST_PAR_BIT] = q.par;
					n.prdata[ST_DIR_BIT] = q.dir;
					n.prdata[ST_OCC_LSB +: 2] = occ;
					n.prdata[ST_PEND_LSB +: 2] = q.pend;
				end
				default: n.prdata = 32'h0;
			endcase
		end

		////////////////////////////////////////////////////////////
		if (apb_wr) begin
			unique case (i_paddr)
				ADR_CTRL: begin
					n.mode = dmfcs_mode_type'(i_pwdata[CTRL_MODE_LSB +: 2]);
					n.lsw = i_pwdata[CTRL_LSW_BIT];
					if (i_pwdata[CTRL_CLR_BIT]) begin
						n.dir = 1'b0;
						n.par = 1'b0;
					end
				end
				ADR_OPA: begin
					n.op_p = i_pwdata[DATA_W-1:0];
					n.op_r = i_pwdata[HI_LSB +: DATA_W];
				end
				ADR_OPB: begin
					n.op_s = i_pwdata[DATA_W-1:0];
					n.op_t = i_pwdata[HI_LSB +: DATA_W];
				end
				ADR_CAS: begin
					n.cas_re = i_pwdata[SUM_W-1:0];
					n.cas_im = i_pwdata[HI_LSB +: SUM_W];
				end
				ADR_SAMPLE: begin
					n.sample = i_pwdata[DATA_W-1:0];
					if (q.mode == MODE_FIR_SYM || q.mode == MODE_FIR_NSYM) begin
						n.st = ST_PUSH;
					end
				end
				ADR_COEF: begin
					// Coefficient load: one word into B or D, enable low one cycle
					if (i_pwdata[COEF_SEL_BIT]) begin
						n.pins.port_d_data = i_pwdata[DATA_W-1:0];
						n.pins.port_d_input_enable_n = 1'b0; // [RQ17]
					end else begin
						n.pins.port_b_data = i_pwdata[DATA_W-1:0];
						n.pins.port_b_input_enable_n = 1'b0; // [RQ17]
					end
				end
				ADR_START: begin
					n.step = TAP_FIRST;
					if (q.mode == MODE_CPX) begin
						n.st = ST_CPX;
					end else if (q.mode == MODE_BFY) begin
						n.st = ST_BFY;
					end
				end
				default: begin
				end
			endcase
		end

		////////////////////////////////////////////////////////////
		unique case (q.st)
			ST_IDLE: begin
			end
			ST_PUSH: begin
				// Entered only once the previous pass result has left the device
				if (q.mode == MODE_FIR_NSYM) begin
					n.pins.port_a_data = q.sample; // [RQ7]
					n.pins.port_c_data = tail; // [RQ7]
					n.pins.port_a_input_enable_n = 1'b0; // [RQ17]
					n.pins.port_c_input_enable_n = 1'b0; // [RQ17]
				end else if (q.par) begin
					n.pins.port_c_data = q.sample; // [RQ4]
					n.pins.port_c_input_enable_n = 1'b0; // [RQ17]
					n.par = 1'b0;
				end else begin
					n.pins.port_a_data = q.sample; // [RQ4]
					n.pins.port_a_input_enable_n = 1'b0; // [RQ17]
					n.par = 1'b1;
				end
				n.step = TAP_FIRST;
				n.st = ST_FIR;
			end
			ST_FIR: begin
				if (q.step != TAP_FIRST || credit_ok) begin
					n.pins.port_a_delay_select = q.step; // [RQ3] [RQ8]
					n.pins.port_c_delay_select = q.step; // [RQ3] [RQ8]
					if (q.mode == MODE_FIR_SYM && q.dir) begin
						n.pins.port_b_delay_select = rev_step; // [RQ5]
						n.pins.port_d_delay_select = rev_step; // [RQ5]
					end else begin
						n.pins.port_b_delay_select = q.step; // [RQ5] [RQ8]
						n.pins.port_d_delay_select = q.step; // [RQ5] [RQ8]
					end
					// First tap reloads, the rest add on [RQ16] [RQ2]
					n.pins.accumulate_control = q.step != TAP_FIRST; // [RQ16]
					n.pins.cascade_data = '0;
					issue = q.step == TAP_FIRST;
					n.step = q.step + SEL_STEP; // [RQ3]
					if (q.step == TAP_LAST) begin
						if (q.mode == MODE_FIR_SYM) begin
							n.dir = !q.dir; // [RQ5]
						end
						n.st = ST_DRAIN;
					end
				end
			end
			ST_CPX: begin
				if (credit_ok) begin
					issue = 1'b1;
					n.pins.port_a_delay_select = TAP_FIRST;
					n.pins.port_b_delay_select = TAP_FIRST;
					n.pins.port_c_delay_select = TAP_FIRST;
					n.pins.port_d_delay_select = TAP_FIRST;
					n.pins.port_a_data = q.op_p;
					n.pins.port_c_data = q.op_r;
					n.pins.port_a_input_enable_n = 1'b0; // [RQ17]
					n.pins.port_b_input_enable_n = 1'b0; // [RQ17]
					n.pins.port_c_input_enable_n = 1'b0; // [RQ17]
					n.pins.port_d_input_enable_n = 1'b0; // [RQ17]
					n.pins.cascade_data = '0;
					if (q.step == TAP_FIRST) begin
						n.pins.port_b_data = q.op_s; // [RQ11]
						n.pins.port_d_data = q.op_t; // [RQ11]
						n.pins.second_product_negate = 1'b1; // [RQ11] [RQ10]
						n.step = q.step + SEL_STEP;
					end else begin
						n.pins.port_b_data = q.op_t; // [RQ11] [RQ14]
						n.pins.port_d_data = q.op_s; // [RQ11] [RQ14]
						n.st = ST_DRAIN;
					end
				end
			end
			ST_BFY: begin
				// Steps are independent sums, so a pause between them is harmless
				if (credit_ok) begin
					issue = 1'b1;
					n.pins.port_a_delay_select = TAP_FIRST;
					n.pins.port_b_delay_select = TAP_FIRST;
					n.pins.port_c_delay_select = TAP_FIRST;
					n.pins.port_d_delay_select = TAP_FIRST;
					n.pins.port_a_data = q.op_p;
					n.pins.port_c_data = q.op_r;
					n.pins.port_a_input_enable_n = 1'b0; // [RQ17]
					n.pins.port_b_input_enable_n = 1'b0; // [RQ17]
					n.pins.port_c_input_enable_n = 1'b0; // [RQ17]
					n.pins.port_d_input_enable_n = 1'b0; // [RQ17]
					if (q.step[1]) begin
						n.pins.port_b_data = q.op_t; // [RQ13]
						n.pins.port_d_data = q.op_s; // [RQ13]
						n.pins.cascade_data = q.cas_im; // [RQ13]
					end else begin
						n.pins.port_b_data = q.op_s;
						n.pins.port_d_data = q.op_t;
						n.pins.cascade_data = q.cas_re;
					end
					unique case (q.step[1:0])
						2'h0: {n.pins.first_product_negate,
							n.pins.second_product_negate} = 2'h1; // [RQ12]
						2'h1: {n.pins.first_product_negate,
							n.pins.second_product_negate} = 2'h2; // [RQ12]
						2'h2: {n.pins.first_product_negate,
							n.pins.second_product_negate} = 2'h0; // [RQ12]
						2'h3: {n.pins.first_product_negate,
							n.pins.second_product_negate} = 2'h3; // [RQ12]
					endcase
					n.step = q.step + SEL_STEP;
					if (q.step[1:0] == 2'h3) begin
						n.st = ST_DRAIN;
					end
				end
			end
			ST_DRAIN: begin
				if (q.mark == '0) begin
					n.st = ST_IDLE;
				end
			end
			default: n.st = ST_IDLE;
		endcase

		////////////////////////////////////////////////////////////
		// FIR takes buffer credit at its first tap but marks the result at its last
		if (issue && q.st != ST_FIR) begin
			n.mark[0] = 1'b1;
		end
		if (q.st == ST_FIR && q.step == TAP_LAST) begin
			n.mark[0] = 1'b1;
		end
		if (issue && !capture) begin
			n.pend = q.pend + 2'h1;
		end else if (capture && !issue) begin
			n.pend = q.pend - 2'h1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			q <= '0;
			q.pins.port_a_input_enable_n <= 1'b1;
			q.pins.port_b_input_enable_n <= 1'b1;
			q.pins.port_c_input_enable_n <= 1'b1;
			q.pins.port_d_input_enable_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////
	dmfcs_shreg u_shreg (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_push(nsym_push),
		.i_data(q.sample),
		.o_tail(tail)
	);

	dmfcs_fifo2 u_fifo (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_in_valid(capture),
		.o_in_ready(fifo_ready),
		.i_in_data(i_dev_sum),
		.o_out_valid(o_res_valid),
		.i_out_ready(i_res_ready),
		.o_out_data(o_res_data),
		.o_count(occ)
	);
endmodule

// ===== logic/dmfcs_pkg.sv
// Shared constants, types and register map for the dual MAC sequencer
package dmfcs_pkg;
	localparam int DATA_W = 12;
	localparam int SUM_W = 16;
	localparam int SEL_W = 4;
	// Cycles from a presented operand set to its output word
	localparam int RES_LAT = 5;
	// Non-symmetric filter: C port delay line length, half of 32 taps
	localparam int HALF_LEN = 16;
	localparam logic [2:0] BUF_DEPTH = 3'h2;
	localparam logic [SEL_W-1:0] TAP_LAST = 4'hF;
	localparam logic [SEL_W-1:0] TAP_FIRST = 4'h0;
	localparam logic [SEL_W-1:0] SEL_STEP = 4'h1;
	////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_START = 8'h04;
	localparam logic [7:0] ADR_SAMPLE = 8'h08;
	localparam logic [7:0] ADR_COEF = 8'h0C;
	localparam logic [7:0] ADR_OPA = 8'h10;
	localparam logic [7:0] ADR_OPB = 8'h14;
	localparam logic [7:0] ADR_CAS = 8'h18;
	localparam logic [7:0] ADR_STATUS = 8'h1C;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_LSW_BIT = 2;
	localparam int CTRL_CLR_BIT = 3;
	localparam int COEF_SEL_BIT = 16;
	localparam int HI_LSB = 16;
	localparam int ST_BUSY_BIT = 8;
	localparam int ST_PAR_BIT = 7;
	localparam int ST_DIR_BIT = 6;
	localparam int ST_OCC_LSB = 2;
	localparam int ST_PEND_LSB = 0;
	////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		MODE_FIR_SYM = 2'h0,
		MODE_FIR_NSYM = 2'h1,
		MODE_CPX = 2'h2,
		MODE_BFY = 2'h3
	} dmfcs_mode_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PUSH = 3'b001,
		ST_FIR = 3'b010,
		ST_CPX = 3'b011,
		ST_BFY = 3'b100,
		ST_DRAIN = 3'b101
	} dmfcs_state_type;
	typedef struct packed {
		logic [DATA_W-1:0] port_a_data;
		logic [DATA_W-1:0] port_b_data;
		logic [DATA_W-1:0] port_c_data;
		logic [DATA_W-1:0] port_d_data;
		logic [SEL_W-1:0] port_a_delay_select;
		logic [SEL_W-1:0] port_b_delay_select;
		logic [SEL_W-1:0] port_c_delay_select;
		logic [SEL_W-1:0] port_d_delay_select;
		logic port_a_input_enable_n;
		logic port_b_input_enable_n;
		logic port_c_input_enable_n;
		logic port_d_input_enable_n;
		logic first_product_negate;
		logic second_product_negate;
		logic round_control;
		logic word_swap;
		logic accumulate_control;
		logic [SUM_W-1:0] cascade_data;
	} dmfcs_pins_type;
endpackage

// ===== logic/dmfcs_fifo2.sv
// Two-entry result buffer with valid/ready on both sides
`timescale 1ns/10ps
module dmfcs_fifo2 import dmfcs_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [SUM_W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [SUM_W-1:0] o_out_data,
	output logic [1:0] o_count
);
	typedef struct packed {
		logic [BUF_DEPTH-1:0][SUM_W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} dmfcs_fifo_state_type;
	dmfcs_fifo_state_type q, n;
	logic push, pop;
	assign o_in_ready = {1'b0, q.cnt} != BUF_DEPTH;
	assign o_out_valid = q.cnt != 2'h0;
	assign o_out_data = q.mem[q.rp];
	assign o_count = q.cnt;
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	always_comb begin
		n = q;
		if (push) begin
			n.mem[q.wp] = i_in_data;
			n.wp = ~q.wp;
		end
		if (pop) begin
			n.rp = ~q.rp;
		end
		if (push && !pop) begin
			n.cnt = q.cnt + 2'h1;
		end else if (pop && !push) begin
			n.cnt = q.cnt - 2'h1;
		end
	end
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule

// ===== logic/dmfcs_shreg.sv
// Half-filter-length delay line feeding the C port in non-symmetric mode
`timescale 1ns/10ps
module dmfcs_shreg import dmfcs_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_push,
	input wire logic [DATA_W-1:0] i_data,
	output logic [DATA_W-1:0] o_tail
);
	typedef struct packed {
		logic [HALF_LEN-1:0][DATA_W-1:0] word;
	} dmfcs_shreg_state_type;
	dmfcs_shreg_state_type q, n;
	assign o_tail = q.word[HALF_LEN-1];
	always_comb begin
		n = q;
		if (i_push) begin
			n.word[0] = i_data;
			for (int k = 1; k < HALF_LEN; k++) begin
				n.word[k] = q.word[k-1];
			end
		end
	end
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule

// ===== testbench/dmfcs_dev_model.sv
// Behavioural model of the dual multiply-accumulate device behind the sequencer
`timescale 1ns/10ps
module dmfcs_dev_model import dmfcs_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rstn,
	input dmfcs_pins_type i_dev,
	output logic [SUM_W-1:0] o_sum
);
	logic signed [DATA_W-1:0] st_q [4][16];
	logic signed [DATA_W-1:0] din [4];
	logic signed [DATA_W-1:0] op [4];
	logic [SEL_W-1:0] sel [4];
	logic en_n [4];
	logic signed [23:0] p1, p2, sum, rnd, acc_q;
	logic [SUM_W-1:0] pipe_q [4];
	assign din = '{i_dev.port_a_data, i_dev.port_b_data, i_dev.port_c_data, i_dev.port_d_data};
	assign sel = '{i_dev.port_a_delay_select, i_dev.port_b_delay_select,
		i_dev.port_c_delay_select, i_dev.port_d_delay_select};
	assign en_n = '{i_dev.port_a_input_enable_n, i_dev.port_b_input_enable_n,
		i_dev.port_c_input_enable_n, i_dev.port_d_input_enable_n};
	////////////////////////////////////////////////////////////////
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			op[p] = (sel[p] == 4'h0) ? din[p] : st_q[p][sel[p] - 4'h1];
		end
		p1 = op[0] * op[1];
		p2 = op[2] * op[3];
		sum = (i_dev.first_product_negate ? -p1 : p1)
			+ (i_dev.second_product_negate ? -p2 : p2)
			+ 24'(signed'(i_dev.cascade_data));
		if (i_dev.accumulate_control)
			sum = sum + acc_q;
		rnd = sum + (i_dev.round_control ? 24'sh80 : 24'sh0);
	end
	// Cleared on reset so that no unknown ever reaches the result buffer
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			acc_q <= '0;
			pipe_q <= '{default: '0};
			st_q <= '{default: '0};
		end else begin
			acc_q <= sum;
			pipe_q[0] <= i_dev.word_swap ? sum[15:0] : rnd[23:8];
			for (int k = 1; k < 4; k++) begin
				pipe_q[k] <= pipe_q[k-1];
			end
			for (int p = 0; p < 4; p++) begin
				if (!en_n[p]) begin
					st_q[p][0] <= din[p];
					for (int k = 1; k < 16; k++) begin
						st_q[p][k] <= st_q[p][k-1];
					end
				end
			end
		end
	end
	assign o_sum = pipe_q[3];
endmodule

// ===== testbench/dmfcs_sva.sv
// Concurrent checks on the sequencer pins, bus answer and result stream
`timescale 1ns/10ps
module dmfcs_sva import dmfcs_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input dmfcs_pins_type o_dev,
	input wire logic o_res_valid,
	input wire logic i_res_ready,
	input wire logic [SUM_W-1:0] o_res_data
);
	logic n1, n2;
	assign n1 = o_dev.first_product_negate;
	assign n2 = o_dev.second_product_negate;
	// A butterfly may pause between its halves for buffer credit, so the swap
	// is judged against the last issued step, not the cycle before
	logic [1:0] last_sg_q;
	logic [DATA_W-1:0] last_b_q, last_d_q;
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			last_sg_q <= 2'h0;
			last_b_q <= '0;
			last_d_q <= '0;
		end else if (!o_dev.port_a_input_enable_n && !o_dev.port_b_input_enable_n) begin
			last_sg_q <= {n1, n2};
			last_b_q <= o_dev.port_b_data;
			last_d_q <= o_dev.port_d_data;
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	////////////////////////////////////////////////////////////////
	sequence s_push;
		$fell(o_dev.port_a_input_enable_n) || $fell(o_dev.port_c_input_enable_n);
	endsequence
	sequence s_tap0;
		o_dev.port_a_delay_select == TAP_FIRST && !o_dev.accumulate_control;
	endsequence
	sequence s_bd_swap;
		o_dev.port_b_data == $past(o_dev.port_d_data)
			&& o_dev.port_d_data == $past(o_dev.port_b_data);
	endsequence
	AST_RESET_PINS: assert property (disable iff (1'b0) !i_rstn |=>
		o_dev.port_a_input_enable_n && o_dev.port_c_input_enable_n && !o_res_valid)
		else $error("pins active after reset");
	// Operand loads hold all enables low on back-to-back steps; a data-only
	// push leaves B idle and lasts one cycle
	AST_EN_PULSE: assert property ($fell(o_dev.port_a_input_enable_n)
		&& o_dev.port_b_input_enable_n |=> o_dev.port_a_input_enable_n
		&& o_dev.port_c_input_enable_n) else $error("enable low too long");
	AST_PUSH_TAP0: assert property (s_push |=> s_tap0)
		else $error("pass not started at tap 0");
	AST_SEL_STEP: assert property (o_dev.accumulate_control |->
		o_dev.port_a_delay_select == $past(o_dev.port_a_delay_select) + SEL_STEP)
		else $error("selector step wrong");
	AST_SEL_PAIRS: assert property (o_dev.port_b_delay_select == o_dev.port_d_delay_select
		&& o_dev.port_a_delay_select == o_dev.port_c_delay_select)
		else $error("selector pairs differ");
	AST_SWAP_RND: assert property (o_dev.word_swap |-> !o_dev.round_control)
		else $error("rounding on lower word");
	AST_CPX_SWAP: assert property ($fell(n2) && !n1 && !$past(n1) |-> s_bd_swap)
		else $error("complex operands not swapped");
	AST_BFY_SWAP: assert property (!o_dev.port_a_input_enable_n
		&& !o_dev.port_b_input_enable_n && !n1 && !n2 && last_sg_q == 2'h2
		|-> o_dev.port_b_data == last_d_q && o_dev.port_d_data == last_b_q)
		else $error("twiddle parts not swapped");
	AST_BFY_LAST: assert property ($rose(n1 && n2) |-> !$past(n1) && !$past(n2))
		else $error("sign order wrong at last step");
	AST_BFY_SECOND: assert property ($rose(n1 && !n2) |-> !$past(n1) && $past(n2))
		else $error("sign order wrong at second step");
	AST_RES_HOLD: assert property (o_res_valid && !i_res_ready |=>
		o_res_valid && $stable(o_res_data)) else $error("result lost under stall");
	AST_APB_READY: assert property (i_psel && i_penable |-> o_pready)
		else $error("bus answer late");
endmodule
bind dmfcs_sequencer dmfcs_sva chk_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_psel(i_psel),
	.i_penable(i_penable), .o_pready(o_pready), .o_dev(o_dev), .o_res_valid(o_res_valid),
	.i_res_ready(i_res_ready), .o_res_data(o_res_data));

// ===== testbench/tb_top.sv
// Self-checking bench for the dual MAC sequencer and its device model
`timescale 1ns/10ps
module tb_top import dmfcs_pkg::*;;
	typedef struct packed {logic [11:0] p, r, s, t; logic [15:0] re, im;} dmfcs_row_type;
	dmfcs_row_type rows [2] = '{'{12'h100, 12'h020, 12'h010, 12'h008, 16'h000F, 16'h000A},
		'{12'h800, 12'h7FF, 12'h7FF, 12'h7FF, 16'h8018, 16'hFFF8}};
	logic i_clock, i_rstn, psel, penable, pwrite, pready, pslverr, rerr, res_valid, res_ready;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [SUM_W-1:0] dev_sum, res_data;
	logic [SUM_W-1:0] got [32];
	dmfcs_pins_type dev;
	int mismatches, cmp_count, cyc, n_got, rd_idx;
	dmfcs_sequencer dut_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_dev(dev),
		.i_dev_sum(dev_sum), .o_res_valid(res_valid), .i_res_ready(res_ready),
		.o_res_data(res_data));
	dmfcs_dev_model dev_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_dev(dev), .o_sum(dev_sum));
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Idle cycle before each setup so psel is never assigned twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		do @(posedge i_clock); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic step(input logic [1:0] ng, input logic [11:0] b, input logic [11:0] d,
		input logic [15:0] cs, input logic ck);
		for (int k = 0; k < 30; k++) begin
			@(posedge i_clock);
			#1;
			// Stall cycles idle the signs too; only an issued step loads operands
			if ({dev.first_product_negate, dev.second_product_negate} === ng
				&& dev.port_b_input_enable_n === 1'b0) break;
		end
		chk("signs", ng, {dev.first_product_negate, dev.second_product_negate});
		chk("b_data", b, dev.port_b_data);
		chk("d_data", d, dev.port_d_data);
		if (ck)
			chk("cascade", cs, dev.cascade_data);
	endtask
	task automatic res(input logic [15:0] e, input logic ck);
		for (int k = 0; k < 60 && n_got <= rd_idx; k++) begin
			@(posedge i_clock);
			#1;
		end
		chk("res_valid", 1, n_got > rd_idx);
		if (ck)
			chk("result", e, got[rd_idx[4:0]]);
		rd_idx++;
	endtask
	task automatic fir(input logic [11:0] x, input logic par, input logic ns);
		apb(1'b1, ADR_SAMPLE, {20'h0, x});
		@(posedge i_clock);
		#1;
		chk("push_en", 0, par ? dev.port_c_input_enable_n : dev.port_a_input_enable_n);
		chk("push_data", x, par ? dev.port_c_data : dev.port_a_data);
		if (ns)
			chk("c_push", 0, dev.port_c_input_enable_n);
		for (int i = 0; i < 16; i++) begin
			@(posedge i_clock);
			#1;
			chk("a_sel", i, dev.port_a_delay_select);
			chk("b_sel", par ? 15 - i : i, dev.port_b_delay_select);
			chk("acc", i != 0, dev.accumulate_control);
		end
		res(16'h0, 1'b0);
		$display("Filter pass done");
	endtask
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			finish_test;
		end
	end
	// Every popped word is logged, so no result slips by between checks
	always @(posedge i_clock) begin
		if (res_valid === 1'b1 && res_ready === 1'b1) begin
			got[n_got[4:0]] <= res_data;
			n_got <= n_got + 1;
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{i_rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		res_ready = 1'b1;
		repeat (4) @(posedge i_clock);
		chk("rst_en", 4'hF, {dev.port_a_input_enable_n, dev.port_b_input_enable_n,
			dev.port_c_input_enable_n, dev.port_d_input_enable_n});
		chk("rst_valid", 0, res_valid);
		i_rstn <= 1'b1;
		apb(1'b0, ADR_STATUS, 32'h0);
		chk("status", 0, rdat);
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", 1, rerr);
		$display("Reset and map test done");
		foreach (rows[n]) begin
			apb(1'b1, ADR_CTRL, 32'h2);
			apb(1'b1, ADR_OPA, {4'h0, rows[n].r, 4'h0, rows[n].p});
			apb(1'b1, ADR_OPB, {4'h0, rows[n].t, 4'h0, rows[n].s});
			apb(1'b1, ADR_START, 32'h0);
			step(2'b01, rows[n].s, rows[n].t, 16'h0, 1'b0);
			step(2'b00, rows[n].t, rows[n].s, 16'h0, 1'b0);
			res(rows[n].re, 1'b1);
			res(rows[n].im, 1'b1);
			$display("Complex row %0d done", n);
		end
		apb(1'b1, ADR_CTRL, 32'h8);
		apb(1'b1, ADR_COEF, 32'h0001_0ABC);
		#1;
		chk("coef_en", 0, dev.port_d_input_enable_n);
		chk("coef", 12'hABC, dev.port_d_data);
		fir(12'h123, 1'b0, 1'b0);
		fir(12'h456, 1'b1, 1'b0);
		apb(1'b1, ADR_CTRL, 32'h9);
		fir(12'h789, 1'b0, 1'b1);
		apb(1'b1, ADR_CTRL, 32'h7);
		apb(1'b1, ADR_OPA, 32'h0003_0005);
		apb(1'b1, ADR_OPB, 32'h0002_0007);
		apb(1'b1, ADR_CAS, 32'h0200_0100);
		apb(1'b1, ADR_START, 32'h0);
		step(2'b01, 12'h007, 12'h002, 16'h0100, 1'b1);
		step(2'b10, 12'h007, 12'h002, 16'h0100, 1'b1);
		step(2'b00, 12'h002, 12'h007, 16'h0200, 1'b1);
		step(2'b11, 12'h002, 12'h007, 16'h0200, 1'b1);
		res(16'h011D, 1'b1);
		res(16'h00E3, 1'b1);
		res(16'h021F, 1'b1);
		res(16'h01E1, 1'b1);
		$display("Butterfly done");
		apb(1'b1, ADR_CTRL, 32'h2);
		apb(1'b1, ADR_OPA, {4'h0, rows[1].r, 4'h0, rows[1].p});
		apb(1'b1, ADR_OPB, {4'h0, rows[1].t, 4'h0, rows[1].s});
		res_ready <= 1'b0;
		apb(1'b1, ADR_START, 32'h0);
		repeat (30) @(posedge i_clock);
		apb(1'b0, ADR_STATUS, 32'h0);
		chk("occupancy", 2, rdat[3:2]);
		res_ready <= 1'b1;
		res(rows[1].re, 1'b1);
		res(rows[1].im, 1'b1);
		$display("Stall test done");
		finish_test;
	end
endmodule
